// ### csr_pkg.sv
// Package for the core system register group: offsets, field positions,
// reset values, operation codes and the packed carriers shared by the block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
`default_nettype none

package csr_pkg;

	// ****************************************************************
	// Register addresses on the 8-bit register address bus.
	// ****************************************************************
	localparam logic [7:0] ADDR_INT_CTRL = 8'hE6;
	localparam logic [7:0] ADDR_FLAGS = 8'hE7;
	localparam logic [7:0] ADDR_PTR_LOW = 8'hE8;
	localparam logic [7:0] ADDR_PTR_HIGH = 8'hE9;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [7:0] RST_INT_CTRL = 8'h87;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_PTR = 8'h00;
	localparam logic [2:0] RST_NEST_LVL = 3'h7;
	localparam logic [4:0] RST_BLK_HI = 5'h01;

	// ****************************************************************
	// Field positions of the interrupt control register.
	// ****************************************************************
	localparam int ICR_GLOBAL_TIMER_COUNT_ENABLE = 7;
	localparam int ICR_PEND = 6;
	localparam int ICR_GATE = 5;
	localparam int ICR_IEN = 4;
	localparam int ICR_ARB = 3;

	// ****************************************************************
	// Field positions of the status flag register.
	// ****************************************************************
	localparam int FL_C = 7;
	localparam int FL_Z = 6;
	localparam int FL_S = 5;
	localparam int FL_V = 4;
	localparam int FL_DA = 3;
	localparam int FL_H = 2;
	localparam int FL_RSV = 1;
	localparam int FL_DP = 0;

	// ****************************************************************
	// Pointer register fields and the depth of the saved flag stack.
	// ****************************************************************
	localparam int PTR_SCHEME = 2;
	localparam int SAVE_DEPTH = 7;

	// Single-cycle operation codes from instruction execution.
	typedef enum logic [3:0] {
		CSR_OP_NONE = 4'h0,
		CSR_OP_EI = 4'h1,
		CSR_OP_DI = 4'h2,
		CSR_OP_SCF = 4'h3,
		CSR_OP_RCF = 4'h4,
		CSR_OP_CCF = 4'h5,
		CSR_OP_SDM = 4'h6,
		CSR_OP_SPM = 4'h7,
		CSR_OP_SRP = 4'h8,
		CSR_OP_SET_LOW_POINTER_OP = 4'h9,
		CSR_OP_SET_HIGH_POINTER_OP = 4'hA,
		CSR_OP_IRET = 4'hB
	} csr_op_t;

	// Flag update from the arithmetic unit.
	typedef struct packed {
		logic upd;        // Zero, sign and overflow update.
		logic upd_c;      // Carry update.
		logic upd_bcd;    // Decimal-kind and half-carry update.
		logic word;       // Word operation.
		logic [15:0] res; // Accumulator result.
		logic carry;      // Carry out of the top bit.
		logic ovf;        // Two's-complement overflow.
		logic sub;        // Operation was a subtraction.
		logic half;       // Carry out of or borrow into bit 3.
	} csr_alu_t;

	// Whole state of the block.
	typedef struct packed {
		logic [7:0] icr;
		logic [7:0] flags;
		logic [7:0] ptr_lo;
		logic [7:0] ptr_hi;
		logic [2:0] nest_lvl;
		logic [2:0] depth;
		logic [SAVE_DEPTH-1:0][7:0] save;
		logic [7:0] rdata;
		logic timer_en;
		logic top_ack_ok;
		logic irq_ok;
		logic [4:0] blk_lo;
		logic [4:0] blk_hi;
	} csr_state_t;

endpackage : csr_pkg

`default_nettype wire

// ### csr_core_regs.sv
// Core system registers: interrupt control, status flags, working pointers.
// Assumes the instruction logic and interrupt controller drive the op and
// event inputs as one-cycle pulses on clk, with no pin crossing needed.
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire csr_pkg::csr_op_t op,
	input wire logic [4:0] op_block,
	input wire csr_pkg::csr_alu_t alu,
	input wire logic top_req,
	input wire logic irq_ack,
	input wire logic [2:0] irq_level,
	input wire logic timer_ce,
	input wire logic top_mask,
	output logic timer_run,
	output logic top_ack_allowed,
	output logic irq_allowed,
	output logic [7:0] int_ctrl,
	output logic [7:0] flags,
	output logic [2:0] nesting_level,
	output logic [2:0] saved_count,
	output logic [4:0] block_low,
	output logic [4:0] block_high
);

	// ****************************************************************
	// State and next state.
	// ****************************************************************
	csr_pkg::csr_state_t st_r; // Every flip-flop of the block.
	csr_pkg::csr_state_t st_nxt; // Next value of the whole state.

	// Local shorthands, filled at the top of the combinational process.
	logic [7:0] ires; // Result byte used for the byte flags.
	logic top_bit; // Result top bit for byte or word.
	logic is_zero; // Result is zero at the operation's width.
	logic [2:0] lvl_nxt; // Priority level after this cycle.

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	// Register writes come first, then hardware events, so that a hardware
	// event in the same cycle as a software write has the final word.
	always_comb
	begin
		st_nxt = st_r;
		ires = alu.res[7:0];
		top_bit = alu.word ? alu.res[15] : alu.res[7];
		is_zero = alu.word ? (alu.res == 16'h0000) : (ires == 8'h00);
		lvl_nxt = st_r.icr[2:0];

		// Software writes from the register bus.
		if (reg_wr)
		begin
			case (reg_addr)
				csr_pkg::ADDR_INT_CTRL:
				begin
					// Writing one sets pending; a zero clears it.
					st_nxt.icr = reg_wdata;
				end
				csr_pkg::ADDR_FLAGS:
				begin
					st_nxt.flags = reg_wdata;
				end
				csr_pkg::ADDR_PTR_LOW:
				begin
					st_nxt.ptr_lo = {reg_wdata[7:2], 2'b00};
				end
				csr_pkg::ADDR_PTR_HIGH:
				begin
					st_nxt.ptr_hi = {reg_wdata[7:2], 2'b00};
				end
				default:
				begin
					// Other addresses belong to other blocks.
				end
			endcase
		end

		// Top-level request from the interrupt controller; set wins.
		if (top_req)
		begin
			st_nxt.icr[csr_pkg::ICR_PEND] = 1'b1;
		end

		// Instruction-driven operations.
		case (op)
			csr_pkg::CSR_OP_EI:
			begin
				st_nxt.icr[csr_pkg::ICR_IEN] = 1'b1;
			end
			csr_pkg::CSR_OP_DI:
			begin
				st_nxt.icr[csr_pkg::ICR_IEN] = 1'b0;
			end
			csr_pkg::CSR_OP_SCF:
			begin
				st_nxt.flags[csr_pkg::FL_C] = 1'b1;
			end
			csr_pkg::CSR_OP_RCF:
			begin
				st_nxt.flags[csr_pkg::FL_C] = 1'b0;
			end
			csr_pkg::CSR_OP_CCF:
			begin
				st_nxt.flags[csr_pkg::FL_C] = ~st_r.flags[csr_pkg::FL_C];
			end
			csr_pkg::CSR_OP_SDM:
			begin
				st_nxt.flags[csr_pkg::FL_DP] = 1'b1;
			end
			csr_pkg::CSR_OP_SPM:
			begin
				st_nxt.flags[csr_pkg::FL_DP] = 1'b0;
			end
			csr_pkg::CSR_OP_SRP:
			begin
				// Single mode: only the low pointer carries the block.
				st_nxt.ptr_lo = {op_block, 3'b000};
				st_nxt.ptr_hi[csr_pkg::PTR_SCHEME] = 1'b0;
			end
			csr_pkg::CSR_OP_SET_LOW_POINTER_OP:
			begin
				st_nxt.ptr_lo = {op_block, 3'b100};
				st_nxt.ptr_hi[csr_pkg::PTR_SCHEME] = 1'b1;
			end
			csr_pkg::CSR_OP_SET_HIGH_POINTER_OP:
			begin
				st_nxt.ptr_hi = {op_block, 3'b100};
				st_nxt.ptr_lo[csr_pkg::PTR_SCHEME] = 1'b1;
			end
			csr_pkg::CSR_OP_IRET:
			begin
				// Return: restore the flags, level and enable.
				st_nxt.icr[csr_pkg::ICR_IEN] = 1'b1;
				lvl_nxt = st_r.nest_lvl;
				if (st_r.depth != 3'd0)
				begin
					st_nxt.flags = st_r.save[0];
					for (int i = 0; i < csr_pkg::SAVE_DEPTH - 1; i++)
					begin
						st_nxt.save[i] = st_r.save[i + 1];
					end
					st_nxt.depth = st_r.depth - 3'd1;
				end
			end
			default:
			begin
				// No operation this cycle.
			end
		endcase

		// Flag updates from the arithmetic unit.
		if (alu.upd)
		begin
			st_nxt.flags[csr_pkg::FL_Z] = is_zero;
			st_nxt.flags[csr_pkg::FL_S] = top_bit;
			st_nxt.flags[csr_pkg::FL_V] = alu.ovf;
		end
		if (alu.upd_c)
		begin
			st_nxt.flags[csr_pkg::FL_C] = alu.carry;
		end
		if (alu.upd_bcd)
		begin
			st_nxt.flags[csr_pkg::FL_DA] = alu.sub;
			st_nxt.flags[csr_pkg::FL_H] = alu.half;
		end

		// Interrupt acknowledge: save flags, save level, load new one.
		if (irq_ack)
		begin
			st_nxt.icr[csr_pkg::ICR_IEN] = 1'b0;
			st_nxt.nest_lvl = st_r.icr[2:0];
			lvl_nxt = irq_level;
			// The stack is seven deep; a further push drops the oldest.
			for (int i = csr_pkg::SAVE_DEPTH - 1; i > 0; i--)
			begin
				st_nxt.save[i] = st_r.save[i - 1];
			end
			st_nxt.save[0] = st_r.flags;
			if (st_r.depth != 3'(csr_pkg::SAVE_DEPTH))
			begin
				st_nxt.depth = st_r.depth + 3'd1;
			end
		end
		if (op == csr_pkg::CSR_OP_IRET || irq_ack)
		begin
			st_nxt.icr[2:0] = lvl_nxt;
		end

		// The reserved flag bit never holds a one.
		st_nxt.flags[csr_pkg::FL_RSV] = 1'b0;

		// Derived outputs, all registered.
		st_nxt.rdata = 8'h00;
		case (reg_addr)
			csr_pkg::ADDR_INT_CTRL: st_nxt.rdata = st_nxt.icr;
			csr_pkg::ADDR_FLAGS: st_nxt.rdata = st_nxt.flags;
			csr_pkg::ADDR_PTR_LOW: st_nxt.rdata = st_nxt.ptr_lo;
			csr_pkg::ADDR_PTR_HIGH: st_nxt.rdata = st_nxt.ptr_hi;
			default: st_nxt.rdata = 8'h00;
		endcase
		st_nxt.timer_en = st_nxt.icr[csr_pkg::ICR_GLOBAL_TIMER_COUNT_ENABLE] & timer_ce;
		// Top level: mask alone, or mask and global enable.
		st_nxt.top_ack_ok = top_mask &
			(~st_nxt.icr[csr_pkg::ICR_GATE] |
			st_nxt.icr[csr_pkg::ICR_IEN]);
		st_nxt.irq_ok = st_nxt.icr[csr_pkg::ICR_IEN];
		// Twin mode uses each pointer; single mode rounds down to even.
		if (st_nxt.ptr_lo[csr_pkg::PTR_SCHEME])
		begin
			st_nxt.blk_lo = st_nxt.ptr_lo[7:3];
			st_nxt.blk_hi = st_nxt.ptr_hi[7:3];
		end
		else
		begin
			st_nxt.blk_lo = {st_nxt.ptr_lo[7:4], 1'b0};
			st_nxt.blk_hi = {st_nxt.ptr_lo[7:4], 1'b1};
		end
	end

	// ****************************************************************
	// State register.
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_r <= '0;
			st_r.icr <= csr_pkg::RST_INT_CTRL;
			st_r.flags <= csr_pkg::RST_FLAGS;
			st_r.ptr_lo <= csr_pkg::RST_PTR;
			st_r.ptr_hi <= csr_pkg::RST_PTR;
			st_r.nest_lvl <= csr_pkg::RST_NEST_LVL;
			st_r.top_ack_ok <= 1'b0;
			// Pointers at zero mean single mode, blocks 0 and 1.
			st_r.blk_hi <= csr_pkg::RST_BLK_HI;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the flip-flops.
	assign reg_rdata = st_r.rdata;
	assign timer_run = st_r.timer_en;
	assign top_ack_allowed = st_r.top_ack_ok;
	assign irq_allowed = st_r.irq_ok;
	assign int_ctrl = st_r.icr;
	assign flags = st_r.flags;
	assign nesting_level = st_r.nest_lvl;
	assign saved_count = st_r.depth;
	assign block_low = st_r.blk_lo;
	assign block_high = st_r.blk_hi;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	// All checks run on the core clock and sleep while reset is high.
	// Derived outputs are registered from the next state, so a check on
	// one of them compares it with the register contents of the same cycle.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_reset_ctrl_val: assert property ($fell(srst) |-> int_ctrl == 8'h87)
		else $error("control reset value wrong");
	a_reset_flag_val: assert property ($fell(srst) |-> flags == 8'h00)
		else $error("flag reset value wrong");
	a_ack_clears_ien: assert property (irq_ack |=> !int_ctrl[4])
		else $error("ack did not clear enable");
	a_top_req_sets: assert property (top_req |=> int_ctrl[6])
		else $error("top request not pending");
	a_ack_saves_level: assert property (irq_ack |=>
		nesting_level == $past(int_ctrl[2:0])
		&& int_ctrl[2:0] == $past(irq_level))
		else $error("ack level handling wrong");
	a_scf_sets_c: assert property (op == csr_pkg::CSR_OP_SCF
		&& !alu.upd_c |=> flags[7])
		else $error("carry not set");
	a_rsv_bit_zero: assert property (flags[1] == 1'b0)
		else $error("reserved flag bit set");
	// The mapped blocks are registered with the pointer, so both are
	// compared in the same cycle; a mode change then cannot trip it.
	a_single_even: assert property (!st_r.ptr_lo[2] |->
		block_low[0] == 1'b0 && block_high == {block_low[4:1], 1'b1})
		else $error("single block not even");
	a_ptr_low_zero: assert property (st_r.ptr_lo[1:0] == 2'b00)
		else $error("pointer low bits set");
	// Saved copies never hold the reserved bit, so the whole byte matches.
	a_iret_restore: assert property (op == csr_pkg::CSR_OP_IRET
		&& !irq_ack && saved_count != 3'd0 && !alu.upd && !alu.upd_c
		&& !alu.upd_bcd |=> flags == $past(st_r.save[0]))
		else $error("flags not restored");
	// Timers run only when the global and per-timer enables are both set.
	a_timer_gate: assert property (!srst |=>
		timer_run == (int_ctrl[7] & $past(timer_ce)))
		else $error("timer enable wrong");
	// Top-level acknowledge follows the gate select and the mask.
	a_top_gate: assert property (!srst |=>
		top_ack_allowed == ($past(top_mask) & (!int_ctrl[5] | int_ctrl[4])))
		else $error("top acknowledge gate wrong");

	// Main scenarios that the bench is expected to reach.
	c_ack_seen: cover property (irq_ack);
	c_iret_seen: cover property (op == csr_pkg::CSR_OP_IRET && saved_count != 0);
	c_twin_mode: cover property (op == csr_pkg::CSR_OP_SET_HIGH_POINTER_OP);
	c_full_stack: cover property (saved_count == 3'd7);
	c_top_seen: cover property (top_req);

endmodule : csr_core_regs

`default_nettype wire

// ### csr_cpu_model.sv
// Model of the instruction and interrupt logic that drives the register group.
// Assumes the bench calls its tasks and that clk is the core clock.
`timescale 1ns/1ps
`default_nettype none

module csr_cpu_model (
	input wire logic clk,
	output var csr_pkg::csr_op_t op,
	output logic [4:0] op_block,
	output var csr_pkg::csr_alu_t alu,
	output logic top_req,
	output logic irq_ack,
	output logic [2:0] irq_level,
	output logic timer_ce,
	output logic top_mask
);

	// ****************************************************************
	// Drivers: each pulse lasts one clock, then a quiet clock follows.
	// ****************************************************************

	// Quiet levels at time zero.
	initial
	begin
		op = csr_pkg::CSR_OP_NONE;
		op_block = 5'h0;
		alu = '0;
		top_req = 1'b0;
		irq_ack = 1'b0;
		irq_level = 3'h7;
		timer_ce = 1'b0;
		top_mask = 1'b0;
	end

	// Released operands show their inverse so stale values never help.
	task automatic do_op(input csr_pkg::csr_op_t o, input logic [4:0] b);
		@(negedge clk);
		op = o;
		op_block = b;
		@(negedge clk);
		op = csr_pkg::CSR_OP_NONE;
		op_block = ~b;
		@(negedge clk);
	endtask : do_op

	// One flag update from the arithmetic unit.
	task automatic do_alu(input csr_pkg::csr_alu_t a);
		@(negedge clk);
		alu = a;
		@(negedge clk);
		alu = ~a;
		alu.upd = 1'b0;
		alu.upd_c = 1'b0;
		alu.upd_bcd = 1'b0;
		@(negedge clk);
	endtask : do_alu

	// One acknowledge cycle at the given priority.
	task automatic do_ack(input logic [2:0] l);
		@(negedge clk);
		irq_ack = 1'b1;
		irq_level = l;
		@(negedge clk);
		irq_ack = 1'b0;
		irq_level = ~l;
		@(negedge clk);
	endtask : do_ack

	// One recognised top-level request.
	task automatic do_top();
		@(negedge clk);
		top_req = 1'b1;
		@(negedge clk);
		top_req = 1'b0;
		@(negedge clk);
	endtask : do_top

	// Levels of the timer enable and the top-level mask.
	task automatic set_lvl(input logic tm, input logic tc);
		@(negedge clk);
		top_mask = tm;
		timer_ce = tc;
	endtask : set_lvl

endmodule : csr_cpu_model

`default_nettype wire

// ### test_core_system_registers.sv
// Self-checking bench for the core system register group.
// Assumes csr_pkg, csr_core_regs and csr_cpu_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_core_system_registers;

	logic clk;
	logic srst;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] int_ctrl;
	logic [7:0] flags;
	csr_pkg::csr_op_t op;
	csr_pkg::csr_alu_t alu;
	logic [4:0] op_block;
	logic [4:0] block_low;
	logic [4:0] block_high;
	logic top_req, irq_ack, timer_ce, top_mask;
	logic timer_run, top_ack_allowed, irq_allowed;
	logic [2:0] irq_level, nesting_level, saved_count;
	int err_count = 0;
	int checks_done = 0;
	csr_pkg::csr_op_t fop [6] = '{csr_pkg::CSR_OP_SCF, csr_pkg::CSR_OP_CCF,
		csr_pkg::CSR_OP_CCF, csr_pkg::CSR_OP_RCF, csr_pkg::CSR_OP_SDM,
		csr_pkg::CSR_OP_SPM};
	logic [7:0] fex [6] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00};

	csr_core_regs uut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.op(op), .op_block(op_block), .alu(alu), .top_req(top_req),
		.irq_ack(irq_ack), .irq_level(irq_level), .timer_ce(timer_ce),
		.top_mask(top_mask), .timer_run(timer_run),
		.top_ack_allowed(top_ack_allowed), .irq_allowed(irq_allowed),
		.int_ctrl(int_ctrl), .flags(flags), .nesting_level(nesting_level),
		.saved_count(saved_count), .block_low(block_low),
		.block_high(block_high));

	csr_cpu_model cpu (.clk(clk), .op(op), .op_block(op_block), .alu(alu),
		.top_req(top_req), .irq_ack(irq_ack), .irq_level(irq_level),
		.timer_ce(timer_ce), .top_mask(top_mask));

	// ****************************************************************
	// Clock, reset, watchdog and shared tasks.
	// ****************************************************************

	// The 100 MHz core clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The tests need under a thousand cycles; this is far beyond that.
	initial
	begin
		#100000;
		err_count++;
		results();
	end

	// Compares one value and counts the outcome.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One bus write; the strobe drops after one clock, then a quiet clock.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
		@(negedge clk);
	endtask : wr

	// Read data is registered, so it is sampled one clock later.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		check(reg_rdata, exp);
	endtask : rd

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial
	begin
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		repeat (10) @(negedge clk);
		srst = 1'b0;
		check(int_ctrl, 8'h87);
		check(flags, 8'h00);
		check(8'(nesting_level), 8'h07);
		check(8'(saved_count), 8'h00);
		check(8'(block_low), 8'h00);
		check(8'(block_high), 8'h01);
		$display("reset test done");
		// Reserved and forced bits, unmapped places.
		wr(8'hE7, 8'hFF);
		rd(8'hE7, 8'hFD);
		wr(8'hE8, 8'hFF);
		rd(8'hE8, 8'hFC);
		rd(8'hE0, 8'h00);
		wr(8'hE5, 8'h55);
		rd(8'hE6, 8'h87);
		$display("register test done");
		// Odd block in single mode rounds down.
		cpu.do_op(csr_pkg::CSR_OP_SRP, 5'h3);
		check(8'(block_low), 8'h02);
		check(8'(block_high), 8'h03);
		cpu.do_op(csr_pkg::CSR_OP_SET_LOW_POINTER_OP, 5'h5);
		cpu.do_op(csr_pkg::CSR_OP_SET_HIGH_POINTER_OP, 5'h9);
		check(8'(block_low), 8'h05);
		check(8'(block_high), 8'h09);
		rd(8'hE8, 8'h2C);
		rd(8'hE9, 8'h4C);
		$display("pointer test done");
		wr(8'hE7, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			cpu.do_op(fop[i], 5'h0);
			check(flags, fex[i]);
		end
		cpu.do_alu('{upd: 1'b1, res: 16'hFF00, ovf: 1'b1, default: 1'b0});
		check(flags, 8'h50);
		cpu.do_alu('{upd: 1'b1, word: 1'b1, res: 16'h8000, default: 1'b0});
		check(flags, 8'h20);
		cpu.do_alu('{upd_c: 1'b1, carry: 1'b1, default: 1'b0});
		check(flags, 8'hA0);
		cpu.do_alu('{upd_bcd: 1'b1, sub: 1'b1, half: 1'b1, default: 1'b0});
		check(flags, 8'hAC);
		$display("flag test done");
		// Requests are masked before every control write.
		cpu.do_op(csr_pkg::CSR_OP_DI, 5'h0);
		wr(8'hE6, 8'h08);
		cpu.do_op(csr_pkg::CSR_OP_EI, 5'h0);
		check(int_ctrl, 8'h18);
		check(8'(irq_allowed), 8'h01);
		cpu.do_ack(3'h5);
		check(int_ctrl, 8'h0D);
		check(8'(nesting_level), 8'h00);
		check(8'(saved_count), 8'h01);
		check(8'(irq_allowed), 8'h00);
		wr(8'hE7, 8'h00);
		cpu.do_op(csr_pkg::CSR_OP_IRET, 5'h0);
		check(flags, 8'hAC);
		check(int_ctrl, 8'h18);
		check(8'(saved_count), 8'h00);
		$display("interrupt test done");
		cpu.do_op(csr_pkg::CSR_OP_DI, 5'h0);
		check(int_ctrl, 8'h08);
		cpu.set_lvl(1'b1, 1'b1);
		wr(8'hE6, 8'h00);
		check(8'(top_ack_allowed), 8'h01);
		check(8'(timer_run), 8'h00);
		wr(8'hE6, 8'h20);
		check(8'(top_ack_allowed), 8'h00);
		wr(8'hE6, 8'hB0);
		check(8'(top_ack_allowed), 8'h01);
		check(8'(timer_run), 8'h01);
		check(8'(irq_allowed), 8'h01);
		// Per-timer enable low stops the timers; mask low stops top ack.
		cpu.set_lvl(1'b1, 1'b0);
		@(negedge clk);
		check(8'(timer_run), 8'h00);
		cpu.set_lvl(1'b0, 1'b0);
		@(negedge clk);
		check(8'(top_ack_allowed), 8'h00);
		cpu.do_op(csr_pkg::CSR_OP_DI, 5'h0);
		cpu.do_top();
		check(int_ctrl, 8'hE0);
		wr(8'hE6, 8'h20);
		wr(8'hE6, 8'h60);
		check(int_ctrl, 8'h60);
		repeat (8) cpu.do_ack(3'h1);
		check(8'(saved_count), 8'h07);
		$display("control test done");
		// A second reset in mid-run brings back the reset values.
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check(int_ctrl, 8'h87);
		check(flags, 8'h00);
		check(8'(saved_count), 8'h00);
		check(8'(block_high), 8'h01);
		$display("second reset test done");
		results();
	end

endmodule : test_core_system_registers

`default_nettype wire
